// [asu_cfg.svh]
`ifndef ASU_CFG_SVH
`define ASU_CFG_SVH

// register byte offsets
`define ASU_OFS_DATA    12'h000
`define ASU_OFS_FLAGS   12'h018
`define ASU_OFS_ILPR    12'h020
`define ASU_OFS_IBRD    12'h024
`define ASU_OFS_FBRD    12'h028
`define ASU_OFS_LCR     12'h02C
`define ASU_OFS_CTRL    12'h030
`define ASU_OFS_IFLS    12'h034
`define ASU_OFS_IMSC    12'h038
`define ASU_OFS_RIS     12'h03C
`define ASU_OFS_MIS     12'h040
`define ASU_OFS_ICR     12'h044
`define ASU_OFS_DMACR   12'h048

// line control fields
`define ASU_LCR_BRK     0
`define ASU_LCR_PEN     1
`define ASU_LCR_EPS     2
`define ASU_LCR_STP2    3
`define ASU_LCR_FEN     4
`define ASU_LCR_WLEN_LO 5
`define ASU_LCR_WLEN_HI 6
`define ASU_LCR_SPS     7

// control fields
`define ASU_CR_EN       0
`define ASU_CR_SIREN    1
`define ASU_CR_SIRLP    2
`define ASU_CR_LBE      7
`define ASU_CR_TXE      8
`define ASU_CR_RXE      9
`define ASU_CR_DTR      10
`define ASU_CR_RTS      11
`define ASU_CR_RTSEN    14
`define ASU_CR_CTSEN    15

// interrupt bits
`define ASU_INT_RI      0
`define ASU_INT_CTS     1
`define ASU_INT_DCD     2
`define ASU_INT_DSR     3
`define ASU_INT_RX      4
`define ASU_INT_TX      5
`define ASU_INT_RT      6
`define ASU_INT_FE      7
`define ASU_INT_PE      8
`define ASU_INT_BE      9
`define ASU_INT_OE      10

// reset values
`define ASU_CTRL_RESET  16'h0300
`define ASU_IFLS_RESET  6'h12

// timing
`define ASU_CLK_HZ        40000000
`define ASU_LP_HZ         1843200
`define ASU_LP_DIV_RESET  ((`ASU_CLK_HZ + `ASU_LP_HZ / 2) / `ASU_LP_HZ)
`define ASU_START_TICK    4'h7
`define ASU_LAST_TICK     4'hF
`define ASU_RT_TICKS      10'h200
`define ASU_SIR_PULSE     2'h3

`endif

// [asu_pkg.sv]
`default_nettype none
package asu_pkg;

	typedef enum logic [4:0] {
		TX_IDLE  = 5'b00001,
		TX_START = 5'b00010,
		TX_DATA  = 5'b00100,
		TX_PAR   = 5'b01000,
		TX_STOP  = 5'b10000
	} asu_tx_e;

	typedef enum logic [4:0] {
		RX_IDLE  = 5'b00001,
		RX_START = 5'b00010,
		RX_DATA  = 5'b00100,
		RX_PAR   = 5'b01000,
		RX_STOP  = 5'b10000
	} asu_rx_e;

endpackage
`default_nettype wire

// [asu_fifo_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface asu_fifo_if #(
	parameter int W     = 8,
	parameter int DEPTH = 16
);
	logic                       push;
	logic [W-1:0]               wdata;
	logic                       pop;
	logic [W-1:0]               rdata;
	logic [$clog2(DEPTH):0]     level;
	logic                       full;
	logic                       empty;
	logic                       one_deep;

	modport owner (output push, wdata, pop, one_deep, input rdata, level, full, empty);
	modport store (input push, wdata, pop, one_deep, output rdata, level, full, empty);
endinterface
`default_nettype wire

// [asu_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module asu_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 16
) (
	input  wire logic clk_sys,
	input  wire logic rst,
	asu_fifo_if.store q
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             lvl;
	} asu_fifo_s;

	asu_fifo_s s;
	asu_fifo_s next_s;
	logic      do_push;
	logic      do_pop;
	logic [AW:0] cap;

	// one-deep mode keeps the storage but caps the fill flag
	assign cap     = q.one_deep ? (AW+1)'(1) : (AW+1)'(DEPTH);
	assign q.full  = s.lvl >= cap;
	assign q.empty = s.lvl == '0;
	assign q.level = s.lvl;
	assign q.rdata = s.mem[s.rp];

	// a push into a full store is dropped, stored words stay put
	always_comb begin
		next_s  = s;
		do_push = q.push && !q.full;
		do_pop  = q.pop && !q.empty;
		if (do_push) begin
			next_s.mem[s.wp] = q.wdata;
			next_s.wp        = AW'(s.wp + 1'b1);
		end
		if (do_pop) begin
			next_s.rp = AW'(s.rp + 1'b1);
		end
		next_s.lvl = (AW+1)'(s.lvl + (AW+1)'(do_push) - (AW+1)'(do_pop));
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	property p_full_drop;
		@(posedge clk_sys) disable iff (rst)
		(q.full && q.push && !q.pop) |=> (s.lvl == $past(s.lvl)) && (s.wp == $past(s.wp));
	endproperty
	a_full_drop: assert property (p_full_drop) else $error("push into full store changed it");

	property p_one_deep;
		@(posedge clk_sys) disable iff (rst)
		(q.one_deep && s.lvl <= 1) |=> (s.lvl <= 1);
	endproperty
	a_one_deep: assert property (p_one_deep) else $error("one-deep store holds more than one");
endmodule
`default_nettype wire

// [asu_core.sv]
// What this block does
// - tx and rx buffers hold 16 entries, or one when buffering is off
// - trigger level selectable at 1/8, 1/4, 1/2, 3/4 or 7/8 of depth
// - one shared oversample tick from integer plus fractional divisor
// - line rates up to 460.8 kbit/s when the reference clock allows
// - rx, timeout, tx, modem and error interrupts each with a mask
// - one combined interrupt output for any active unmasked source
// - dma request outputs on every instance built with HAS_DMA set
// - framing, parity, break errors flagged and stored with the character
// - overrun flag set at once, new character dropped, buffer kept
// - modem inputs cts, dcd, dsr, ri read and changes reported
// - dtr output driven by its software bit; rts by its bit too, or by receive level when auto-rts is on
// - flow control: cts gates sending, rts shows receive room
// - bus reset or block reset returns everything to initial state
// - serial to parallel on receive, parallel to serial on transmit
// - low-power infrared pulse timed from nominal 1.8432 MHz divider
// - frame format and rate from line control and two divisor registers
// - divisor is 16-bit integer plus 6-bit fraction, ref/(16 x rate)
// - rx entry: data 7:0, framing/parity/break 10:8, overrun bit 11
// - start confirmed on eighth tick, then a sample each sixteenth tick
// - busy rises with non-empty tx buffer, falls after last stop bit
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "asu_cfg.svh"
module asu_core #(
	parameter int FIFO_DEPTH = 16,
	parameter bit HAS_DMA    = 1'b1
) (
	input  wire logic        clk_sys,
	input  wire logic        srst,
	input  wire logic        block_reset_n,
	input  wire logic [11:0] addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata,
	input  wire logic        rxd,
	output logic             txd,
	output logic             sir_out,
	input  wire logic        clear_to_send_n,
	input  wire logic        dcd_n,
	input  wire logic        dsr_n,
	input  wire logic        ri_n,
	output logic             request_to_send_n,
	output logic             dtr_n,
	output logic             irq,
	output logic             tx_dma_req,
	output logic             rx_dma_req,
	output logic             busy
);
	localparam int LW = $clog2(FIFO_DEPTH) + 1;

	typedef struct packed {
		logic [15:0]      divisor_integer_reg;
		logic [5:0]       divisor_fraction_reg;
		logic [7:0]       line_control_reg;
		logic [15:0]      ctrl;
		logic [5:0]       ifls;
		logic [10:0]      imsc;
		logic [10:0]      ris;
		logic [1:0]       dmacr;
		logic [7:0]       ilpr;
		logic [15:0]      bcnt;
		logic [5:0]       facc;
		logic             oversample_tick;
		logic [7:0]       lpcnt;
		logic             lptick;
		asu_pkg::asu_tx_e tst;
		logic [3:0]       ttk;
		logic [2:0]       tbit;
		logic [7:0]       tsh;
		logic             tpar;
		logic             tstop;
		logic [1:0]       sirw;
		asu_pkg::asu_rx_e rxst;
		logic [3:0]       rtk;
		logic [2:0]       rbit;
		logic [7:0]       rsh;
		logic             rpe;
		logic             rparv;
		logic             ovr_pend;
		logic [9:0]       idle;
		logic [3:0]       mprev;
		logic [31:0]      rdata;
		logic             txd;
		logic             sir_out;
		logic             rts_n;
		logic             dtr_n;
		logic             irq;
		logic             tx_dma;
		logic             rx_dma;
		logic             busy;
	} asu_core_s;

	asu_core_s s;
	asu_core_s next_s;
	logic      rst;
	logic      rx_line;
	logic      cts_ok;
	logic      fen;
	logic [1:0] wlen;
	logic [LW-1:0] rx_trig;
	logic [LW-1:0] tx_trig;

	asu_fifo_if #(.W(12), .DEPTH(FIFO_DEPTH)) rx_q ();
	asu_fifo_if #(.W(8),  .DEPTH(FIFO_DEPTH)) tx_q ();

	////////////////////////////////////////////////////////////////////////////////
	// helpers shared by both directions
	function automatic logic [7:0] dmask(input logic [1:0] wl);
		dmask = 8'hFF >> (2'd3 - wl);
	endfunction

	function automatic logic par_bit(input logic [7:0] d, input logic [1:0] wl,
	                                 input logic eps, input logic sps);
		logic [7:0] m;
		m = d & dmask(wl);
		if (sps) begin
			par_bit = ~eps;
		end else begin
			par_bit = eps ? ^m : ~^m;
		end
	endfunction

	// trigger depth per setting; one-deep mode always triggers at one
	function automatic logic [LW-1:0] trig_lvl(input logic [2:0] code, input logic fe);
		if (!fe) begin
			trig_lvl = LW'(1);
		end else begin
			case (code)
				3'd0:    trig_lvl = LW'(FIFO_DEPTH / 8);
				3'd1:    trig_lvl = LW'(FIFO_DEPTH / 4);
				3'd2:    trig_lvl = LW'(FIFO_DEPTH / 2);
				3'd3:    trig_lvl = LW'(FIFO_DEPTH * 3 / 4);
				3'd4:    trig_lvl = LW'(FIFO_DEPTH * 7 / 8);
				default: trig_lvl = LW'(FIFO_DEPTH / 2);
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	assign rst      = srst | ~block_reset_n;
	assign fen      = s.line_control_reg[`ASU_LCR_FEN];
	assign wlen     = s.line_control_reg[`ASU_LCR_WLEN_HI:`ASU_LCR_WLEN_LO];
	assign rx_line  = s.ctrl[`ASU_CR_LBE] ? s.txd : rxd;
	assign cts_ok   = !s.ctrl[`ASU_CR_CTSEN] || !clear_to_send_n;
	assign rx_trig  = trig_lvl(s.ifls[5:3], fen);
	assign tx_trig  = trig_lvl(s.ifls[2:0], fen);
	assign rx_q.one_deep = !fen;
	assign tx_q.one_deep = !fen;

	asu_fifo #(.W(12), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.clk_sys (clk_sys),
		.rst     (rst),
		.q       (rx_q.store)
	);

	asu_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.clk_sys (clk_sys),
		.rst     (rst),
		.q       (tx_q.store)
	);

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [6:0]  fsum;
		logic        bit_end;
		logic        sample;
		logic        go;
		logic        lv;
		logic [7:0]  rdat;
		logic [10:0] set_v;
		logic [10:0] clr_v;
		logic [3:0]  mnow;
		fsum = 7'h00;
		bit_end = s.oversample_tick && (s.ttk == `ASU_LAST_TICK);
		sample = s.oversample_tick && (s.rtk == `ASU_LAST_TICK);
		go = 1'b0;
		lv = 1'b1;
		rdat = (s.rsh >> (2'd3 - wlen)) & dmask(wlen);
		set_v = 11'h000;
		clr_v = 11'h000;
		mnow = {ri_n, dsr_n, dcd_n, clear_to_send_n};
		next_s = s;
		rx_q.push = 1'b0;
		rx_q.wdata = 12'h000;
		rx_q.pop = rd && (addr == `ASU_OFS_DATA);
		tx_q.push = wr && (addr == `ASU_OFS_DATA);
		tx_q.wdata = wdata[7:0];
		tx_q.pop = 1'b0;

		// fractional divider: a carry out of the fraction stretches one period
		next_s.oversample_tick = 1'b0;
		if (s.divisor_integer_reg != 16'h0000) begin
			if (s.bcnt == 16'h0000) begin
				fsum = {1'b0, s.facc} + {1'b0, s.divisor_fraction_reg};
				next_s.facc = fsum[5:0];
				next_s.bcnt = 16'(s.divisor_integer_reg - 16'h0001 + {15'h0000, fsum[6]});
				next_s.oversample_tick = 1'b1;
			end else begin
				next_s.bcnt = 16'(s.bcnt - 16'h0001);
			end
		end

		// low-power divider for the short infrared pulse
		next_s.lptick = 1'b0;
		if (s.lpcnt == 8'h00) begin
			next_s.lpcnt = (s.ilpr == 8'h00) ? 8'h00 : 8'(s.ilpr - 8'h01);
			next_s.lptick = s.ilpr != 8'h00;
		end else begin
			next_s.lpcnt = 8'(s.lpcnt - 8'h01);
		end

		// register writes
		if (wr) begin
			case (addr)
				`ASU_OFS_IBRD:  next_s.divisor_integer_reg = wdata[15:0];
				`ASU_OFS_FBRD:  next_s.divisor_fraction_reg = wdata[5:0];
				`ASU_OFS_LCR:   next_s.line_control_reg = wdata[7:0];
				`ASU_OFS_CTRL:  next_s.ctrl = wdata[15:0];
				`ASU_OFS_IFLS:  next_s.ifls = wdata[5:0];
				`ASU_OFS_IMSC:  next_s.imsc = wdata[10:0];
				`ASU_OFS_ICR:   clr_v = wdata[10:0];
				`ASU_OFS_DMACR: next_s.dmacr = wdata[1:0];
				`ASU_OFS_ILPR:  next_s.ilpr = wdata[7:0];
				default:        clr_v = 11'h000;
			endcase
		end

		// register reads, data valid one cycle after the strobe
		next_s.rdata = 32'h0000_0000;
		if (rd) begin
			case (addr)
				`ASU_OFS_DATA:  next_s.rdata = {20'h00000, rx_q.rdata};
				`ASU_OFS_FLAGS: next_s.rdata = {23'h000000, ~ri_n, tx_q.empty, rx_q.full,
				                 tx_q.full, rx_q.empty, s.busy, ~dcd_n, ~dsr_n,
				                 ~clear_to_send_n};
				`ASU_OFS_IBRD:  next_s.rdata = {16'h0000, s.divisor_integer_reg};
				`ASU_OFS_FBRD:  next_s.rdata = {26'h0000000, s.divisor_fraction_reg};
				`ASU_OFS_LCR:   next_s.rdata = {24'h000000, s.line_control_reg};
				`ASU_OFS_CTRL:  next_s.rdata = {16'h0000, s.ctrl};
				`ASU_OFS_IFLS:  next_s.rdata = {26'h0000000, s.ifls};
				`ASU_OFS_IMSC:  next_s.rdata = {21'h000000, s.imsc};
				`ASU_OFS_RIS:   next_s.rdata = {21'h000000, s.ris};
				`ASU_OFS_MIS:   next_s.rdata = {21'h000000, s.ris & s.imsc};
				`ASU_OFS_DMACR: next_s.rdata = {30'h00000000, s.dmacr};
				`ASU_OFS_ILPR:  next_s.rdata = {24'h000000, s.ilpr};
				default:        next_s.rdata = 32'h0000_0000;
			endcase
		end

		// transmitter: one bit per sixteen ticks
		next_s.ttk = 4'(s.ttk + {3'h0, s.oversample_tick});
		case (s.tst)
			asu_pkg::TX_IDLE: begin
				next_s.ttk = 4'h0;
				if (s.ctrl[`ASU_CR_EN] && s.ctrl[`ASU_CR_TXE] && !tx_q.empty && cts_ok
				    && s.oversample_tick) begin
					tx_q.pop = 1'b1;
					next_s.tsh = tx_q.rdata;
					next_s.tpar = par_bit(tx_q.rdata, wlen, s.line_control_reg[`ASU_LCR_EPS],
					                      s.line_control_reg[`ASU_LCR_SPS]);
					next_s.tst = asu_pkg::TX_START;
					go = 1'b1;
				end
			end
			asu_pkg::TX_START: if (bit_end) begin
				next_s.tst = asu_pkg::TX_DATA;
				next_s.tbit = 3'h0;
				go = 1'b1;
			end
			asu_pkg::TX_DATA: if (bit_end) begin
				next_s.tsh = s.tsh >> 1;
				go = 1'b1;
				if (s.tbit == 3'(3'd4 + {1'b0, wlen})) begin
					next_s.tstop = 1'b0;
					next_s.tst = s.line_control_reg[`ASU_LCR_PEN] ? asu_pkg::TX_PAR :
					             asu_pkg::TX_STOP;
				end else begin
					next_s.tbit = 3'(s.tbit + 3'h1);
				end
			end
			asu_pkg::TX_PAR: if (bit_end) begin
				next_s.tst = asu_pkg::TX_STOP;
				go = 1'b1;
			end
			asu_pkg::TX_STOP: if (bit_end) begin
				go = 1'b1;
				if (s.line_control_reg[`ASU_LCR_STP2] && !s.tstop) begin
					next_s.tstop = 1'b1;
				end else begin
					next_s.tst = asu_pkg::TX_IDLE;
				end
			end
			default: next_s.tst = asu_pkg::TX_IDLE;
		endcase
		case (next_s.tst)
			asu_pkg::TX_START: lv = 1'b0;
			asu_pkg::TX_DATA:  lv = next_s.tsh[0];
			asu_pkg::TX_PAR:   lv = s.tpar;
			default:           lv = 1'b1;
		endcase
		// break holds the line low regardless of the frame in flight
		next_s.txd = lv && !s.line_control_reg[`ASU_LCR_BRK];
		// infrared: a short pulse per zero bit, normal or low-power width
		if (go && !lv) begin
			next_s.sirw = `ASU_SIR_PULSE;
		end else if (s.sirw != 2'h0 &&
		             (s.ctrl[`ASU_CR_SIRLP] ? s.lptick : s.oversample_tick)) begin
			next_s.sirw = 2'(s.sirw - 2'h1);
		end
		next_s.sir_out = s.ctrl[`ASU_CR_SIREN] && (next_s.sirw != 2'h0);

		// receiver
		next_s.rtk = 4'(s.rtk + {3'h0, s.oversample_tick});
		case (s.rxst)
			asu_pkg::RX_IDLE: begin
				next_s.rtk = 4'h0;
				if (s.ctrl[`ASU_CR_EN] && s.ctrl[`ASU_CR_RXE] && !rx_line) begin
					next_s.rxst = asu_pkg::RX_START;
				end
			end
			asu_pkg::RX_START: if (s.oversample_tick && s.rtk == `ASU_START_TICK) begin
				next_s.rtk = 4'h0;
				next_s.rbit = 3'h0;
				next_s.rsh = 8'h00;
				next_s.rxst = rx_line ? asu_pkg::RX_IDLE : asu_pkg::RX_DATA;
			end
			asu_pkg::RX_DATA: if (sample) begin
				next_s.rsh = {rx_line, s.rsh[7:1]};
				if (s.rbit == 3'(3'd4 + {1'b0, wlen})) begin
					next_s.rxst = s.line_control_reg[`ASU_LCR_PEN] ? asu_pkg::RX_PAR :
					              asu_pkg::RX_STOP;
					next_s.rpe = 1'b0;
					next_s.rparv = 1'b0;
				end else begin
					next_s.rbit = 3'(s.rbit + 3'h1);
				end
			end
			asu_pkg::RX_PAR: if (sample) begin
				next_s.rparv = rx_line;
				next_s.rpe = rx_line != par_bit(rdat, wlen, s.line_control_reg[`ASU_LCR_EPS],
				                                 s.line_control_reg[`ASU_LCR_SPS]);
				next_s.rxst = asu_pkg::RX_STOP;
			end
			asu_pkg::RX_STOP: if (sample) begin
				set_v[`ASU_INT_FE] = !rx_line;
				set_v[`ASU_INT_PE] = s.rpe;
				set_v[`ASU_INT_BE] = !rx_line && rdat == 8'h00 && !s.rparv;
				next_s.rxst = asu_pkg::RX_IDLE;
				if (rx_q.full) begin
					set_v[`ASU_INT_OE] = 1'b1;
					next_s.ovr_pend = 1'b1;
				end else begin
					rx_q.push = 1'b1;
					rx_q.wdata = {s.ovr_pend, set_v[`ASU_INT_BE], s.rpe, !rx_line, rdat};
					next_s.ovr_pend = 1'b0;
				end
			end
			default: next_s.rxst = asu_pkg::RX_IDLE;
		endcase

		// idle timer restarts on any movement of the receive buffer
		if (rx_q.empty || rx_q.push || rx_q.pop) begin
			next_s.idle = 10'h000;
		end else if (s.oversample_tick && s.idle != `ASU_RT_TICKS) begin
			next_s.idle = 10'(s.idle + 10'h001);
		end
		set_v[`ASU_INT_RT] = s.idle == `ASU_RT_TICKS;

		// level and modem sources; set wins over a clear in the same cycle
		set_v[`ASU_INT_RX] = rx_q.level >= rx_trig;
		set_v[`ASU_INT_TX] = fen ? (tx_q.level <= tx_trig) : tx_q.empty;
		set_v[`ASU_INT_CTS] = mnow[0] ^ s.mprev[0];
		set_v[`ASU_INT_DCD] = mnow[1] ^ s.mprev[1];
		set_v[`ASU_INT_DSR] = mnow[2] ^ s.mprev[2];
		set_v[`ASU_INT_RI] = mnow[3] ^ s.mprev[3];
		next_s.mprev = mnow;
		next_s.ris = (s.ris & ~clr_v) | set_v;
		next_s.irq = |(s.ris & s.imsc);

		// pins and requests
		next_s.rts_n = s.ctrl[`ASU_CR_RTSEN] ? (rx_q.level >= rx_trig) :
		               !s.ctrl[`ASU_CR_RTS];
		next_s.dtr_n = !s.ctrl[`ASU_CR_DTR];
		next_s.tx_dma = HAS_DMA && s.dmacr[0] && !tx_q.full && (tx_q.level <= tx_trig);
		next_s.rx_dma = HAS_DMA && s.dmacr[1] && !rx_q.empty;
		next_s.busy = !tx_q.empty || s.tst != asu_pkg::TX_IDLE;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s <= '0;
			s.ctrl <= `ASU_CTRL_RESET;
			s.ifls <= `ASU_IFLS_RESET;
			s.ilpr <= 8'(`ASU_LP_DIV_RESET);
			s.tst <= asu_pkg::TX_IDLE;
			s.rxst <= asu_pkg::RX_IDLE;
			s.mprev <= 4'hF;
			s.txd <= 1'b1;
			s.rts_n <= 1'b1;
			s.dtr_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign rdata             = s.rdata;
	assign txd               = s.txd;
	assign sir_out           = s.sir_out;
	assign request_to_send_n = s.rts_n;
	assign dtr_n             = s.dtr_n;
	assign irq               = s.irq;
	assign tx_dma_req        = s.tx_dma;
	assign rx_dma_req        = s.rx_dma;
	assign busy              = s.busy;

	////////////////////////////////////////////////////////////////////////////////
	property p_busy_rise;
		@(posedge clk_sys) disable iff (rst)
		(wr && addr == `ASU_OFS_DATA && !tx_q.full) |-> ##2 busy;
	endproperty
	a_busy_rise: assert property (p_busy_rise) else $error("busy missing after tx push");

	property p_irq;
		@(posedge clk_sys) disable iff (rst)
		(|(s.ris & s.imsc)) [*2] |-> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("combined interrupt not raised");

	property p_overrun;
		@(posedge clk_sys) disable iff (rst)
		(s.rxst == asu_pkg::RX_STOP && s.oversample_tick && s.rtk == `ASU_LAST_TICK
		 && rx_q.full && !rx_q.pop) |=> (s.ris[`ASU_INT_OE] && rx_q.level == $past(rx_q.level));
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun did not keep buffer");

	property p_false_start;
		@(posedge clk_sys) disable iff (rst)
		(s.rxst == asu_pkg::RX_START && s.oversample_tick && s.rtk == `ASU_START_TICK
		 && rx_line) |=> s.rxst == asu_pkg::RX_IDLE;
	endproperty
	a_false_start: assert property (p_false_start) else $error("false start accepted");

	property p_rts_flow;
		@(posedge clk_sys) disable iff (rst)
		(s.ctrl[`ASU_CR_RTSEN] && rx_q.level >= rx_trig) |=> request_to_send_n;
	endproperty
	a_rts_flow: assert property (p_rts_flow) else $error("rts asserted above watermark");

	property p_cts_hold;
		@(posedge clk_sys) disable iff (rst)
		(s.ctrl[`ASU_CR_CTSEN] && clear_to_send_n && s.tst == asu_pkg::TX_IDLE)
		|=> s.tst == asu_pkg::TX_IDLE;
	endproperty
	a_cts_hold: assert property (p_cts_hold) else $error("sent while cts deasserted");

	property p_frame_err;
		@(posedge clk_sys) disable iff (rst)
		(s.rxst == asu_pkg::RX_STOP && s.oversample_tick && s.rtk == `ASU_LAST_TICK
		 && !rx_line && !rx_q.full) |=> (s.ris[`ASU_INT_FE] && rx_q.level != '0);
	endproperty
	a_frame_err: assert property (p_frame_err) else $error("framing error not stored");

	property p_dtr;
		@(posedge clk_sys) disable iff (rst)
		(wr && addr == `ASU_OFS_CTRL) |-> ##2 (dtr_n == !$past(wdata[`ASU_CR_DTR], 2));
	endproperty
	a_dtr: assert property (p_dtr) else $error("dtr does not follow control");

	property p_no_dma;
		@(posedge clk_sys) disable iff (rst)
		!HAS_DMA |-> (!tx_dma_req && !rx_dma_req);
	endproperty
	a_no_dma: assert property (p_no_dma) else $error("dma request without dma");
endmodule
`default_nettype wire

// [asu_peer.sv]
`timescale 1ns/1ps
`default_nettype none
// far serial end: decodes frames on txd, sends frames on rxd
module asu_peer #(
	parameter int BIT = 16
) (
	input  wire logic clk_sys,
	input  wire logic txd,
	output var  logic rxd
);
	logic [7:0] seen;
	int         n_seen;
	initial begin
		rxd = 1'b1;
		n_seen = 0;
	end
	// mid-bit sampling, lsb first; only a good stop bit counts
	always begin
		@(negedge txd);
		repeat (BIT / 2) @(posedge clk_sys);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge clk_sys);
			seen[i] = txd;
		end
		repeat (BIT) @(posedge clk_sys);
		if (txd === 1'b1) n_seen++;
	end
	// stop low gives the receiver a broken frame
	task automatic send(input logic [7:0] b, input logic stop);
		logic [9:0] f;
		f = {stop, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (BIT) @(posedge clk_sys);
		end
		rxd <= 1'b1;
	endtask
endmodule
`default_nettype wire

// [asu_core_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "asu_cfg.svh"
module asu_core_tb;
	logic        clk_sys = 1'b0;
	logic        srst = 1'b1;
	logic        block_reset_n = 1'b1;
	logic [11:0] addr = 12'h000;
	logic [31:0] wdata = 32'h0000_0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        ri_n = 1'b1;
	logic        cts_n = 1'b0;
	logic        dcd_n = 1'b1;
	logic        dsr_n = 1'b1;
	logic [31:0] rdata;
	logic        txd, rxd, sir_out, request_to_send_n, dtr_n, irq, txq, rxq, busy;
	int          miscompares = 0;
	int          comparisons = 0;
	int          sir_hi = 0;
	always #12.5 clk_sys = ~clk_sys;
	asu_core dut (.clk_sys(clk_sys), .srst(srst), .block_reset_n(block_reset_n),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd),
		.txd(txd), .sir_out(sir_out), .clear_to_send_n(cts_n), .dcd_n(dcd_n),
		.dsr_n(dsr_n), .ri_n(ri_n), .request_to_send_n(request_to_send_n),
		.dtr_n(dtr_n), .irq(irq), .tx_dma_req(txq), .rx_dma_req(rxq), .busy(busy));
	asu_peer peer (.clk_sys(clk_sys), .txd(txd), .rxd(rxd));
	// infrared pulse length in clocks, summed over the run
	always @(posedge clk_sys) begin
		if (sir_out === 1'b1) sir_hi++;
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic results;
		$display("miscompares %0d comparisons %0d", miscompares, comparisons);
		if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// one-cycle strobes, changed just after the edge
	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 check(rdata, exp);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// bounded wait for the transmitter to drain; running out is a mismatch
	task automatic wait_idle;
		int i;
		for (i = 0; i < 400 && busy !== 1'b0; i++) #25;
		if (i == 400) begin
			miscompares++;
			results();
		end
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rd_chk(`ASU_OFS_CTRL, 32'h0000_0300);
		rd_chk(`ASU_OFS_IFLS, 32'h0000_0012);
		rd_chk(12'h0FC, 32'h0000_0000);
		rd_chk(`ASU_OFS_FLAGS, 32'h0000_0091);
		check(32'(txd), 32'h1);
		check(32'(busy), 32'h0);
	endtask
	// divisor 1: one tick a cycle, 16 cycles a bit, 8n1, infrared pulses on
	task automatic t_tx;
		wr_reg(`ASU_OFS_IBRD, 32'h0000_0001);
		wr_reg(`ASU_OFS_LCR, 32'h0000_0060);
		wr_reg(`ASU_OFS_CTRL, 32'h0000_0303);
		wr_reg(`ASU_OFS_DATA, 32'h0000_00A5);
		settle(2);
		check(32'(busy), 32'h1);
		wait_idle();
		check(32'(peer.seen), 32'h0000_00A5);
		check(32'(peer.n_seen), 32'h1);
		// start bit plus four zero data bits, one short pulse each
		check(32'(sir_hi), 32'(5 * `ASU_SIR_PULSE));
	endtask
	task automatic t_rx;
		peer.send(8'h3C, 1'b1);
		settle(4);
		rd_chk(`ASU_OFS_DATA, 32'h0000_003C);
		peer.send(8'h55, 1'b0);
		settle(4);
		rd_chk(`ASU_OFS_DATA, 32'h0000_0155);
	endtask
	// cts held off: the word waits, a second write bounces off the full
	// one-deep buffer; an rx overrun keeps the stored word
	task automatic t_flow;
		cts_n <= 1'b1;
		wr_reg(`ASU_OFS_DMACR, 32'h0000_0003);
		wr_reg(`ASU_OFS_CTRL, 32'h0000_C301);
		wr_reg(`ASU_OFS_DATA, 32'h0000_005A);
		wr_reg(`ASU_OFS_DATA, 32'h0000_00C3);
		settle(40);
		check(32'(txd), 32'h1);
		check(32'(busy), 32'h1);
		check(32'(request_to_send_n), 32'h0);
		check(32'(txq), 32'h0);
		peer.send(8'h81, 1'b1);
		settle(4);
		check(32'(request_to_send_n), 32'h1);
		check(32'(rxq), 32'h1);
		peer.send(8'h7E, 1'b1);
		settle(4);
		cts_n <= 1'b0;
		wait_idle();
		check(32'(peer.seen), 32'h0000_005A);
		check(32'(peer.n_seen), 32'h2);
		rd_chk(`ASU_OFS_DATA, 32'h0000_0081);
		peer.send(8'h42, 1'b1);
		settle(4);
		rd_chk(`ASU_OFS_DATA, 32'h0000_0842);
		settle(2);
		check(32'(txq), 32'h1);
		check(32'(rxq), 32'h0);
	endtask
	// ring change raises the unmasked source; clear drops irq
	task automatic t_modem;
		wr_reg(`ASU_OFS_CTRL, 32'h0000_0F01);
		wr_reg(`ASU_OFS_IMSC, 32'h0000_0001);
		ri_n <= 1'b0;
		dcd_n <= 1'b0;
		dsr_n <= 1'b0;
		settle(4);
		rd_chk(`ASU_OFS_FLAGS, 32'h0000_0197);
		check(32'(request_to_send_n), 32'h0);
		check(32'(dtr_n), 32'h0);
		check(32'(irq), 32'h1);
		rd_chk(`ASU_OFS_MIS, 32'h0000_0001);
		wr_reg(`ASU_OFS_ICR, 32'h0000_0001);
		settle(3);
		check(32'(irq), 32'h0);
	endtask
	task automatic t_block_reset;
		@(posedge clk_sys);
		block_reset_n <= 1'b0;
		@(posedge clk_sys);
		block_reset_n <= 1'b1;
		rd_chk(`ASU_OFS_CTRL, 32'h0000_0300);
		check(32'(request_to_send_n), 32'h1);
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		srst <= 1'b0;
		t_reset();
		t_tx();
		t_rx();
		t_flow();
		t_modem();
		t_block_reset();
		results();
	end
endmodule
`default_nettype wire
